// ---- logic/bank_pkg.sv ----
/*
 Shared constants and types for the backlight and status register bank.
 Assumes a 25 MHz reference clock and a two-wire serial bus whose clock is a
 separate domain.
*/
package bank_pkg;
   // Bus addressing
   localparam logic [6:0] DEV_ADDR = 7'h09;
   localparam logic [1:0] SUB_LDO_BUCK = 2'h0;
   localparam logic [1:0] SUB_BL_CTRL = 2'h1;
   localparam logic [1:0] SUB_BL_CODE = 2'h2;
   localparam logic [1:0] SUB_BL_RATIO = 2'h3;
   localparam int NUM_REGS = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Backlight control field positions
   localparam int BL_EN_BIT = 0;
   localparam int BL_GRAD_LSB = 1;
   localparam int BL_MODE_LSB = 3;
   localparam int BL_CLKSEL_LSB = 5;
   localparam int BL_SLOW_BIT = 7;
   localparam logic [7:0] BL_CODE_MASK = 8'h3F;
   localparam int RATIO_NUM_LSB = 4;

   // Linear regulator enables in the regulator control byte
   localparam int LINREG_EN_LSB = 0;

   // Reference clock and pulse clock rates, in centihertz
   localparam longint REF_CLK_CHZ = 64'd2500000000;
   localparam longint DIM_CHZ_0 = 64'd877000;
   localparam longint DIM_CHZ_1 = 64'd439000;
   localparam longint DIM_CHZ_2 = 64'd292000;
   localparam longint DIM_CHZ_3 = 64'd219000;
   localparam logic [13:0] DIM_DIV_0 = 14'(REF_CLK_CHZ / DIM_CHZ_0);
   localparam logic [13:0] DIM_DIV_1 = 14'(REF_CLK_CHZ / DIM_CHZ_1);
   localparam logic [13:0] DIM_DIV_2 = 14'(REF_CLK_CHZ / DIM_CHZ_2);
   localparam logic [13:0] DIM_DIV_3 = 14'(REF_CLK_CHZ / DIM_CHZ_3);

   typedef enum logic [1:0] {MODE_CC, MODE_PULSE, MODE_HV, MODE_BAD} boost_mode_t;

   typedef struct packed {
      logic boost_switch_slow_edge;
      logic dim_clock_sel_hi;
      logic dim_clock_sel_lo;
      logic boost_mode_bit_hi;
      logic boost_mode_bit_lo;
      logic [1:0] gradation;
      logic enable;
   } bl_ctrl_t;

   typedef struct packed {
      logic [3:0] pulse_ratio_numerator;
      logic [3:0] pulse_ratio_denominator;
   } bl_ratio_t;

   typedef struct packed {
      logic [2:0] stepdown_power_good;
      logic [1:0] linreg_power_good;
      logic [1:0] charger_fault;
      logic charging;
   } power_status_t;

   // Raw asynchronous condition inputs
   typedef struct packed {
      logic [2:0] stepdown_en;
      logic [2:0] stepdown_in_reg;
      logic [1:0] linreg_in_reg;
      logic [1:0] charger_fault;
      logic charging;
   } cond_in_t;

   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_TEMP_RANGE = 2'h1;
   localparam logic [1:0] FAULT_OVERTEMP = 2'h2;
   localparam logic [1:0] FAULT_BATTERY = 2'h3;
endpackage

// ---- logic/backlight_status_bank.sv ----
/*
 Register bank behind the two-wire serial slave port: four write registers
 with holding latches, backlight control decode, and one status byte.
 Assumes the serial clock arrives on scl_clk, SDA is open drain resolved
 outside, and condition inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Mode field bits 4:3 decode 00 constant current, 10 pulse, 01 high voltage.
// - Control bits 6:5 select the pulse dimming clock rate.
// - Control bit 7 picks fast (0) or slow (1) boost switch edges.
// - Brightness code is six bits at sub-address 0x02, bits 5:0.
// - Brightness code maps exponentially, 60dB span, code 63 is full scale.
// - Bits 7:6 of the brightness register have no effect.
// - Sub-address 0x03 holds denominator in bits 3:0, numerator in bits 7:4.
// - Read address returns exactly one status byte, no sub-address.
// - Status is frozen when the read address is acknowledged.
// - Each status bit reads 1 when its condition is true.
// - Bits 7:5 are step-down good: enabled and in regulation.
// - Bits 4:3 are linear regulator good: enabled and in regulation.
// - Bits 2:1 encode charger fault: none, temperature, overtemp, battery.
// - Temperature code shows while charging is paused for thermistor range.
// - Battery fault code shows when low battery persists past half an hour.
// - Bit 0 is 1 during constant-current charge, including temperature pause.
// - All writable registers reset to zero.
// - Clock select 00..11 gives 8.77, 4.39, 2.92, 2.19 kHz.
// - Received data sits in holding latches until a STOP condition.
// - Undervoltage or pushbutton power-down clears every control bit.
module backlight_status_bank
   import bank_pkg::*;
(
   // Clocks and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic scl_clk,
   // Serial data pin
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Power-down sources, asynchronous
   input wire logic supply_ok,
   input wire logic pb_power_down,
   // Conditions, asynchronous
   input wire cond_in_t cond_in,
   // Active control outputs and the status byte
   output logic [7:0] ldo_buck_ctrl,
   output bl_ctrl_t bl_ctrl,
   output boost_mode_t boost_mode,
   output logic dim_tick,
   output logic [5:0] backlight_brightness_code,
   output bl_ratio_t bl_ratio,
   output power_status_t power_status
);

   typedef enum {PH_IDLE, PH_ADDR, PH_SUB, PH_DATA, PH_READ} phase_t;

   function automatic boost_mode_t decode_mode(input logic [1:0] bits);
      case (bits)
         2'h0: decode_mode = MODE_CC;
         2'h2: decode_mode = MODE_PULSE;
         2'h1: decode_mode = MODE_HV;
         default: decode_mode = MODE_BAD;
      endcase
   endfunction

   function automatic logic [13:0] dim_div(input logic [1:0] sel);
      case (sel)
         2'h0: dim_div = DIM_DIV_0;
         2'h1: dim_div = DIM_DIV_1;
         2'h2: dim_div = DIM_DIV_2;
         default: dim_div = DIM_DIV_3;
      endcase
   endfunction

   // START and STOP seen on SDA edges while SCL is high
   logic start_tgl_q;
   logic stop_tgl_q;

   always_ff @(negedge sda_in or negedge arst_n)
   begin
      if (!arst_n)
         start_tgl_q <= 1'b0;
      else if (scl_clk)
         start_tgl_q <= ~start_tgl_q;
   end

   always_ff @(posedge sda_in or negedge arst_n)
   begin
      if (!arst_n)
         stop_tgl_q <= 1'b0;
      else if (scl_clk)
         stop_tgl_q <= ~stop_tgl_q;
   end

   // Link domain, rising SCL: bit capture
   // Start toggle is read unsynchronised: the protocol keeps SDA still
   // around every SCL rise, so it has settled long before.
   logic start_seen_q;
   phase_t phase_q;
   logic [3:0] bit_q;
   logic [7:0] shreg_q;
   logic [1:0] sub_q;
   logic [7:0] hold_q [NUM_REGS];
   logic [NUM_REGS-1:0] wr_tgl_q;
   logic addr_hit;

   assign addr_hit = (shreg_q[7:1] == DEV_ADDR);

   always_ff @(posedge scl_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         start_seen_q <= 1'b0;
         phase_q <= PH_IDLE;
         bit_q <= 4'h0;
         shreg_q <= 8'h00;
         sub_q <= 2'h0;
      end
      else if (start_tgl_q != start_seen_q)
      begin
         start_seen_q <= start_tgl_q;
         phase_q <= PH_ADDR;
         bit_q <= 4'h1;
         shreg_q <= {7'h00, sda_in};
      end
      else if (bit_q != BITS_PER_BYTE)
      begin
         bit_q <= bit_q + 4'h1;
         shreg_q <= {shreg_q[6:0], sda_in};
      end
      else
      begin
         bit_q <= 4'h0;
         case (phase_q)
            PH_ADDR:
            begin
               if (!addr_hit)
                  phase_q <= PH_IDLE;
               else if (shreg_q[0])
                  phase_q <= PH_READ;
               else
                  phase_q <= PH_SUB;
            end
            PH_SUB:
            begin
               // Out-of-map sub-addresses alias onto the four registers
               sub_q <= shreg_q[1:0];
               phase_q <= PH_DATA;
            end
            default:
               phase_q <= PH_IDLE; // One byte only on a read
         endcase
      end
   end

   // Holding latches, loaded as the data byte is acknowledged
   always_ff @(posedge scl_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            hold_q[i] <= REG_RESET;
         wr_tgl_q <= '0;
      end
      else if (phase_q == PH_DATA && bit_q == BITS_PER_BYTE &&
               start_tgl_q == start_seen_q)
      begin
         hold_q[sub_q] <= shreg_q;
         wr_tgl_q[sub_q] <= ~wr_tgl_q[sub_q];
      end
   end

   // Link domain, falling SCL: acknowledge and read data
   power_status_t status_q;
   logic [7:0] snap_q;
   logic drive_low_q;
   logic ack_slot;

   assign ack_slot = (bit_q == BITS_PER_BYTE) &&
                     ((phase_q == PH_ADDR && addr_hit) ||
                      phase_q == PH_SUB || phase_q == PH_DATA);

   // Status bits are captured as levels; a capture racing a change yields old
   // or new per bit, so the two-bit charger fault code at bits 2:1 can read false.
   always_ff @(negedge scl_clk or negedge arst_n)
   begin
      if (!arst_n)
         snap_q <= 8'h00;
      else if (phase_q == PH_ADDR && bit_q == BITS_PER_BYTE && addr_hit && shreg_q[0])
         snap_q <= status_q;
   end

   always_ff @(negedge scl_clk or negedge arst_n)
   begin
      if (!arst_n)
         drive_low_q <= 1'b0;
      else if (ack_slot)
         drive_low_q <= 1'b1;
      else if (phase_q == PH_READ && bit_q < BITS_PER_BYTE)
         drive_low_q <= ~snap_q[3'(4'h7 - bit_q)];
      else
         drive_low_q <= 1'b0;
   end

   assign sda_out = 1'b0;
   assign sda_oe = drive_low_q;

   // Reference domain: synchronisers
   logic [2:0] stop_sync_q;
   logic [1:0] ok_sync_q;
   logic [1:0] pdn_sync_q;
   cond_in_t cond_s1_q;
   cond_in_t cond_s2_q;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stop_sync_q <= 3'h0;
         ok_sync_q <= 2'h0;
         pdn_sync_q <= 2'h0;
         cond_s1_q <= '0;
         cond_s2_q <= '0;
      end
      else
      begin
         stop_sync_q <= {stop_sync_q[1:0], stop_tgl_q};
         ok_sync_q <= {ok_sync_q[0], supply_ok};
         pdn_sync_q <= {pdn_sync_q[0], pb_power_down};
         cond_s1_q <= cond_in;
         cond_s2_q <= cond_s1_q;
      end
   end

   logic stop_pulse;
   logic clear_req;
   assign stop_pulse = stop_sync_q[2] ^ stop_sync_q[1];
   assign clear_req = ~ok_sync_q[1] | pdn_sync_q[1];

   // Active registers, committed on STOP; holding data is quiet by then
   logic [7:0] act_q [NUM_REGS];
   logic [NUM_REGS-1:0] wr_seen_q;

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            act_q[i] <= REG_RESET;
         wr_seen_q <= '0;
      end
      else if (clear_req)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            act_q[i] <= REG_RESET;
         // Stale latched bytes must not revive after power-down
         wr_seen_q <= wr_tgl_q;
      end
      else if (stop_pulse)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            if (wr_tgl_q[i] != wr_seen_q[i])
               act_q[i] <= hold_q[i];
         wr_seen_q <= wr_tgl_q;
      end
   end

   // Decoded control outputs
   assign ldo_buck_ctrl = act_q[SUB_LDO_BUCK];
   assign bl_ctrl = act_q[SUB_BL_CTRL];
   assign boost_mode = decode_mode(act_q[SUB_BL_CTRL][BL_MODE_LSB +: 2]);
   // Code drives the exponential current DAC directly
   assign backlight_brightness_code = act_q[SUB_BL_CODE][5:0];
   assign bl_ratio = act_q[SUB_BL_RATIO];

   // Pulse dimming clock from the selected divider
   logic [13:0] dim_cnt_q;
   logic [13:0] dim_top;
   assign dim_top = dim_div(act_q[SUB_BL_CTRL][BL_CLKSEL_LSB +: 2]);

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         dim_cnt_q <= 14'h0000;
      else if (dim_cnt_q >= dim_top - 14'h0001)
         dim_cnt_q <= 14'h0000;
      else
         dim_cnt_q <= dim_cnt_q + 14'h0001;
   end

   assign dim_tick = (dim_cnt_q == 14'h0000);

   // Status byte: condition true reads 1
   logic [1:0] linreg_en;
   assign linreg_en = act_q[SUB_LDO_BUCK][LINREG_EN_LSB +: 2];

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         status_q <= '0;
      else
      begin
         status_q.stepdown_power_good <=
            cond_s2_q.stepdown_en & cond_s2_q.stepdown_in_reg;
         status_q.linreg_power_good <= linreg_en & cond_s2_q.linreg_in_reg;
         // Charger reports pause, overtemp or timed-out low battery
         status_q.charger_fault <= cond_s2_q.charger_fault;
         status_q.charging <= cond_s2_q.charging;
      end
   end

   assign power_status = status_q;

   // Checks, reference domain
   a_stop_commits: assert property (@(posedge ref_clk) disable iff (!arst_n)
      stop_pulse && !clear_req && wr_tgl_q[SUB_BL_CODE] != wr_seen_q[SUB_BL_CODE]
      |=> act_q[SUB_BL_CODE] == $past(hold_q[SUB_BL_CODE]))
      else $error("brightness not committed on stop");
   a_hold_until_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !stop_pulse && !clear_req |=> $stable(act_q[SUB_BL_RATIO]))
      else $error("ratio changed without stop");
   a_clear_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clear_req |=> bl_ctrl == '0 && ldo_buck_ctrl == 8'h00)
      else $error("control not cleared on power-down");
   a_mode_decode: assert property (@(posedge ref_clk) disable iff (!arst_n)
      bl_ctrl.boost_mode_bit_hi && !bl_ctrl.boost_mode_bit_lo |-> boost_mode == MODE_PULSE)
      else $error("mode 10 not pulse boost");
   a_code_commit: assert property (@(posedge ref_clk) disable iff (!arst_n)
      stop_pulse && !clear_req && wr_tgl_q[SUB_BL_CODE] != wr_seen_q[SUB_BL_CODE]
      |=> backlight_brightness_code == $past(hold_q[SUB_BL_CODE][5:0]))
      else $error("brightness code wrong bits");
   a_linreg_good: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !linreg_en[0] |=> !status_q.linreg_power_good[0])
      else $error("disabled regulator reported good");
   a_cond_sync: assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1 |-> ##3 status_q.charger_fault == $past(cond_in.charger_fault, 3))
      else $error("fault code not two-flop delayed");
   a_charge_bit: assert property (@(posedge ref_clk) disable iff (!arst_n)
      1'b1 |-> ##3 status_q.charging == $past(cond_in.charging, 3))
      else $error("charging bit not two-flop delayed");
   a_dim_period: assert property (@(posedge ref_clk) disable iff (!arst_n)
      dim_tick && $stable(dim_top) |=> !dim_tick [*8])
      else $error("dim tick too frequent");

   // Checks, link domain
   a_ack_address: assert property (@(negedge scl_clk) disable iff (!arst_n)
      phase_q == PH_ADDR && bit_q == BITS_PER_BYTE && !addr_hit
      |-> ##1 !sda_oe)
      else $error("foreign address acknowledged");
   a_snap_frozen: assert property (@(negedge scl_clk) disable iff (!arst_n)
      phase_q == PH_READ && bit_q != 4'h0 |-> $stable(snap_q))
      else $error("snapshot changed during read");
   a_snap_taken: assert property (@(negedge scl_clk) disable iff (!arst_n)
      phase_q == PH_ADDR && bit_q == BITS_PER_BYTE && addr_hit && shreg_q[0]
      |=> snap_q == $past(status_q))
      else $error("snapshot not taken at read acknowledge");
   a_read_release: assert property (@(negedge scl_clk) disable iff (!arst_n)
      phase_q == PH_READ && bit_q == BITS_PER_BYTE |=> !sda_oe)
      else $error("data line held after status byte");

   c_write_commit: cover property (@(posedge ref_clk) disable iff (!arst_n)
      stop_pulse && wr_tgl_q != wr_seen_q);
   c_status_read: cover property (@(negedge scl_clk) disable iff (!arst_n)
      phase_q == PH_READ && bit_q == 4'h7);
   c_power_down: cover property (@(posedge ref_clk) disable iff (!arst_n)
      clear_req && act_q[SUB_BL_CTRL] != 8'h00);
   c_pulse_mode: cover property (@(posedge ref_clk) disable iff (!arst_n)
      boost_mode == MODE_PULSE);
   c_foreign_addr: cover property (@(negedge scl_clk) disable iff (!arst_n)
      phase_q == PH_ADDR && bit_q == BITS_PER_BYTE && !addr_hit);

endmodule

// ---- bench/i2c_host.sv ----
/*
 Behavioural two-wire bus master for the register bank's serial port.
 Assumes a pull-up on SDA: the wire reads high unless someone pulls it low.
*/
`timescale 1ns/1ps
module i2c_host
(
   // Bus pins
   output logic scl,
   output logic sda_drv,
   input wire logic sda_wire
);
   logic [7:0] nacks;

   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
      nacks = 8'h00;
   end

   // One 6 ns bus clock; SDA only moves while SCL is low
   task automatic clk_bit(input logic b, output logic r);
      sda_drv = b;
      #1.5;
      scl = 1'b1;
      #1.5;
      r = sda_wire;
      #1.5;
      scl = 1'b0;
      #1.5;
   endtask

   // Works from idle and as a repeated start
   task automatic start();
      sda_drv = 1'b1;
      #1.5;
      scl = 1'b1;
      #1.7;
      sda_drv = 1'b0;
      #1.5;
      scl = 1'b0;
      #1.5;
   endtask

   // Clock stands high afterwards, until the next frame
   task automatic stop();
      sda_drv = 1'b0;
      #1.5;
      scl = 1'b1;
      #1.5;
      sda_drv = 1'b1;
      #3;
   endtask

   task automatic put_byte(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         clk_bit(b[i], r);
      clk_bit(1'b1, r);
      if (r !== 1'b0)
         nacks = nacks + 8'h01;
   endtask

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] sub, input logic [7:0] d);
      start();
      put_byte(addr);
      put_byte(sub);
      put_byte(d);
   endtask

   // Master answers with a not-acknowledge, then frees the bus
   task automatic read_status(output logic [7:0] b);
      logic r;
      start();
      put_byte(8'h13);
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, r);
         b[i] = r;
      end
      clk_bit(1'b1, r);
      stop();
   endtask
endmodule

// ---- bench/tb.sv ----
/*
 Self-checking bench for the backlight and status register bank.
 Assumes the i2c_host model on the serial port and a 25 MHz reference clock.
*/
`timescale 1ns/1ps
module tb;
   import bank_pkg::*;
   typedef struct {int kind; logic [15:0] val;} note_t;
   localparam int K_LDO = 0, K_CTRL = 1, K_CODE = 2, K_RATIO = 3, K_MODE = 4;
   localparam int K_RD = 5, K_STAT = 6, K_PER = 7, K_NACK = 8;
   // Both start high so that reset falls as a real edge for every flop
   logic ref_clk = 1'b1;
   logic arst_n = 1'b1;
   logic supply_ok = 1'b1;
   logic pb_power_down = 1'b0;
   cond_in_t cond_in = '0;
   logic scl_clk, sda_drv, sda_in, sda_out, sda_oe, dim_tick;
   logic [7:0] ldo_buck_ctrl;
   bl_ctrl_t bl_ctrl;
   boost_mode_t boost_mode;
   logic [5:0] backlight_brightness_code;
   bl_ratio_t bl_ratio;
   power_status_t power_status;
   logic [7:0] r, ldo, ctl, rat, rd_b, e;
   logic [15:0] per;
   int seed = 32'h46C3;
   int n_errors = 0;
   int n_compared = 0;
   note_t exp_q[$];
   note_t n;
   logic [1:0] md [3] = '{2'h0, 2'h2, 2'h1};
   boost_mode_t bm [3] = '{MODE_CC, MODE_PULSE, MODE_HV};
   logic [13:0] dv [4] = '{DIM_DIV_0, DIM_DIV_1, DIM_DIV_2, DIM_DIV_3};

   // Open-drain wire: master and device both only pull low
   assign sda_in = sda_drv & ~(sda_oe & ~sda_out);

   always #20 ref_clk = ~ref_clk;

   i2c_host host (.scl(scl_clk), .sda_drv(sda_drv), .sda_wire(sda_in));

   backlight_status_bank dut (.ref_clk(ref_clk), .arst_n(arst_n), .scl_clk(scl_clk),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .supply_ok(supply_ok),
      .pb_power_down(pb_power_down), .cond_in(cond_in), .ldo_buck_ctrl(ldo_buck_ctrl),
      .bl_ctrl(bl_ctrl), .boost_mode(boost_mode), .dim_tick(dim_tick),
      .backlight_brightness_code(backlight_brightness_code), .bl_ratio(bl_ratio),
      .power_status(power_status));

   task automatic stop_test();
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cmp_reg(input logic [7:0] a, input logic [7:0] x);
      n_compared++;
      if (a !== x)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t byte %h expected %h", $time, a, x);
      end
   endtask

   task automatic cmp_cnt(input logic [15:0] a, input logic [15:0] x);
      n_compared++;
      if (a !== x)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t count %0d expected %0d", $time, a, x);
      end
   endtask

   function automatic logic [7:0] reg_of(input int k);
      case (k)
         K_LDO: return ldo_buck_ctrl;
         K_CTRL: return bl_ctrl;
         K_CODE: return {2'h0, backlight_brightness_code};
         K_RATIO: return bl_ratio;
         K_RD: return rd_b;
         K_STAT: return power_status;
         default: return {6'h00, boost_mode};
      endcase
   endfunction

   function automatic logic [7:0] stat_of(input cond_in_t c);
      return {c.stepdown_en & c.stepdown_in_reg, ldo[1:0] & c.linreg_in_reg,
         c.charger_fault, c.charging};
   endfunction

   task automatic note(input int k, input logic [15:0] v);
      exp_q.push_back('{k, v});
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge ref_clk);
   endtask

   task automatic zeros();
      for (int k = 0; k < 5; k++)
         note(k, 16'h0000);
   endtask

   // Commit follows STOP by a few reference edges
   task automatic wr(input logic [7:0] s, input logic [7:0] d);
      host.write_reg(8'h12, s, d);
      host.stop();
      cyc(6);
   endtask

   task automatic tick_gap(output logic [15:0] g);
      g = 16'h0000;
      do
      begin
         @(negedge ref_clk);
         g++;
      end
      while (dim_tick !== 1'b1);
   endtask

   always
   begin
      wait (exp_q.size() > 0);
      n = exp_q.pop_front();
      if (n.kind == K_PER)
         cmp_cnt(per, n.val);
      else if (n.kind == K_NACK)
         cmp_cnt({8'h00, host.nacks}, n.val);
      else
         cmp_reg(reg_of(n.kind), n.val[7:0]);
   end

   initial
   begin
      #4000000;
      n_errors++;
      stop_test();
   end

   initial
   begin
      @(negedge ref_clk);
      arst_n = 1'b0;
      cyc(20);
      arst_n = 1'b1;
      cyc(4);
      zeros();
      r = 8'($random(seed));
      host.write_reg(8'h12, 8'h02, r);
      cyc(8);
      note(K_CODE, 16'h0000);
      host.stop();
      cyc(6);
      note(K_CODE, {8'h00, r & BL_CODE_MASK});
      ldo = 8'($random(seed));
      ctl = 8'($random(seed));
      ctl[4] = ctl[4] & ~ctl[3];
      rat = 8'($random(seed));
      host.write_reg(8'h12, 8'h00, ldo);
      host.write_reg(8'h12, 8'h01, ctl);
      host.write_reg(8'h12, 8'h03, rat);
      host.stop();
      cyc(6);
      note(K_LDO, {8'h00, ldo});
      note(K_CTRL, {8'h00, ctl});
      note(K_RATIO, {8'h00, rat});
      for (int i = 0; i < 3; i++)
      begin
         wr(8'h01, {3'h0, md[i], 3'h1});
         note(K_MODE, {14'h0000, bm[i]});
      end
      // Second gap is a full period; the first may be cut short by the change
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h01, {1'b0, 2'(s), 5'h00});
         tick_gap(per);
         tick_gap(per);
         note(K_PER, {2'h0, dv[s]});
      end
      for (int f = 0; f < 4; f++)
      begin
         cond_in = cond_in_t'(11'($random(seed)));
         cond_in.charger_fault = 2'(f);
         cyc(5);
         e = stat_of(cond_in);
         // New levels reach the status byte just after the read acknowledge
         cond_in = cond_in_t'(11'($random(seed)));
         cyc(1);
         host.read_status(rd_b);
         cyc(1);
         note(K_RD, {8'h00, e});
         note(K_STAT, {8'h00, stat_of(cond_in)});
      end
      // Foreign address: all three bytes go unanswered
      host.write_reg(8'h14, 8'h02, 8'h3F);
      host.stop();
      cyc(6);
      note(K_NACK, 16'h0003);
      note(K_CODE, {8'h00, r & BL_CODE_MASK});
      for (int j = 0; j < 3; j++)
      begin
         wr(8'h02, 8'h15);
         supply_ok = (j != 0);
         pb_power_down = (j == 1);
         arst_n = (j != 2);
         cyc(4);
         supply_ok = 1'b1;
         pb_power_down = 1'b0;
         arst_n = 1'b1;
         cyc(4);
         zeros();
      end
      wait (exp_q.size() == 0);
      cyc(1);
      stop_test();
   end
endmodule
